// ==== design/bfm_cfg.svh ====
`ifndef BFM_CFG_SVH
`define BFM_CFG_SVH

`define BFM_W 32
`define BFM_FLAG_N 31
`define BFM_FLAG_C 30
`define BFM_FLAG_Z 29
`define BFM_FLAG_V 28
`define BFM_CFG_BITS 6
`define BFM_FE_BIT 5
`define BFM_FS_RST 5'h00
`define BFM_FE_RST 1'b0
`define BFM_UPPER_SWAP 26
`define BFM_UPPER_LEAD 27
`define BFM_LEAD_TOP 5'h1F
`define BFM_DISP_SHIFT 4
`define BFM_SHORT_DIR_BIT 5
`define BFM_SAMPLE_WAIT 2'h3

`endif

// ==== design/bfm_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bfm_cfg.svh"
module bfm_exec (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire bfm_pkg::bfm_req_s REQ,
  input wire bfm_pkg::bfm_line_s LINE_IN,
  input wire logic [31:0] FLAGS,
  input wire logic [31:0] IRQ_MASK,
  input wire logic [31:0] IRQ_PEND,
  input wire logic HALT_SELECT,
  input wire logic EMULATE_EXIT,
  output var bfm_pkg::bfm_res_s RES,
  output logic RES_VALID,
  output logic BAD_DISP,
  output logic GLOBAL_IRQ_ON,
  output logic IRQ_TAKE,
  output logic DEBUG_ACK_N,
  output logic EMULATE_MODE,
  output var bfm_pkg::bfm_fcfg_s FIELD_CFG0,
  output var bfm_pkg::bfm_fcfg_s FIELD_CFG1,
  output logic PIXEL_STB,
  output logic [31:0] PIXEL_ADDR,
  output var bfm_pkg::bfm_line_s LINE_OUT
);
  bfm_pkg::bfm_state_e state_q;
  bfm_pkg::bfm_res_s res_d;
  bfm_pkg::bfm_line_s line_q;
  bfm_pkg::bfm_fcfg_s cfg_sel;
  logic take;
  logic sel_s1_q;
  logic sel_s2_q;
  logic [1:0] wait_q;
  logic [31:0] next_q;
  logic line_var_q;
  logic [31:0] loop_words;
  logic [31:0] loop_mag;
  logic [31:0] loop_off;
  logic [31:0] rel_off;
  logic rel_bad;
  logic [31:0] dec_val;
  logic dec_go;
  logic cond_true;
  logic bad_d;
  logic nz_n;
  logic nz_c;
  logic nz_z;
  logic nz_v;
  logic [4:0] lo_pos;
  logic wait_end;
  logic line_end;
  logic d_pos;
  logic [31:0] line_step;
  logic [31:0] d_next;

  assign REQ_READY = (state_q == bfm_pkg::S_IDLE);
  assign take = REQ_VALID & REQ_READY;
  assign wait_end = (state_q == bfm_pkg::S_WAIT) && (wait_q == (`BFM_SAMPLE_WAIT - 2'h1));
  assign line_end = (state_q == bfm_pkg::S_LINE) && (line_q.count == 16'h0001);
  assign IRQ_TAKE = GLOBAL_IRQ_ON & (|(IRQ_MASK & IRQ_PEND));
  assign LINE_OUT = line_q;

  bfm_lead_one u_lead_one (
    .src(REQ.src),
    .pos(lo_pos)
  );

  // pin from the emulator: two flops before anything looks at it
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
    end else begin
      sel_s1_q <= HALT_SELECT;
      sel_s2_q <= sel_s1_q;
    end
  end

  assign nz_n = FLAGS[`BFM_FLAG_N];
  assign nz_c = FLAGS[`BFM_FLAG_C];
  assign nz_z = FLAGS[`BFM_FLAG_Z];
  assign nz_v = FLAGS[`BFM_FLAG_V];

  always_comb begin
    case (REQ.cond)
      bfm_pkg::CC_ALWAYS: cond_true = 1'b1;
      bfm_pkg::CC_EQ: cond_true = nz_z;
      bfm_pkg::CC_NE: cond_true = ~nz_z;
      bfm_pkg::CC_CS: cond_true = nz_c;
      bfm_pkg::CC_CC: cond_true = ~nz_c;
      bfm_pkg::CC_MI: cond_true = nz_n;
      bfm_pkg::CC_PL: cond_true = ~nz_n;
      bfm_pkg::CC_VS: cond_true = nz_v;
      bfm_pkg::CC_VC: cond_true = ~nz_v;
      bfm_pkg::CC_GT: cond_true = ~nz_z & (nz_n == nz_v);
      bfm_pkg::CC_LE: cond_true = nz_z | (nz_n != nz_v);
      bfm_pkg::CC_GE: cond_true = (nz_n == nz_v);
      bfm_pkg::CC_LT: cond_true = (nz_n != nz_v);
      bfm_pkg::CC_HI: cond_true = ~nz_c & ~nz_z;
      bfm_pkg::CC_LS: cond_true = nz_c | nz_z;
      default: cond_true = 1'b0;
    endcase
  end

  // displacements: short loop form is magnitude-minus-one plus direction bit
  always_comb begin
    loop_mag = {27'h0, REQ.disp[4:0]} + 32'h1;
    if (REQ.long_form) begin
      loop_words = {{16{REQ.disp[15]}}, REQ.disp};
    end else begin
      loop_words = REQ.disp[`BFM_SHORT_DIR_BIT] ? (32'h0 - loop_mag) : loop_mag;
    end
    loop_off = loop_words << `BFM_DISP_SHIFT;
    if (REQ.long_form) begin
      rel_off = {{16{REQ.disp[15]}}, REQ.disp};
      rel_bad = (REQ.disp == 16'h0000) || (REQ.disp == 16'h8000);
    end else begin
      rel_off = {{24{REQ.disp[7]}}, REQ.disp[7:0]};
      rel_bad = (REQ.disp[7:0] == 8'h00) || (REQ.disp[7:0] == 8'h80);
    end
  end

  assign dec_val = REQ.dst - 32'h1;
  assign dec_go = (REQ.op == bfm_pkg::OP_DEC_SKIP) ||
                  ((REQ.op == bfm_pkg::OP_DEC_IF_EQ) && nz_z) ||
                  ((REQ.op == bfm_pkg::OP_DEC_IF_NE) && !nz_z);
  assign cfg_sel = REQ.field_sel ? FIELD_CFG1 : FIELD_CFG0;

  always_comb begin
    res_d = '0;
    res_d.pc = REQ.next_pc;
    bad_d = 1'b0;
    case (REQ.op)
      bfm_pkg::OP_DEC_SKIP, bfm_pkg::OP_DEC_IF_EQ, bfm_pkg::OP_DEC_IF_NE: begin
        if (dec_go) begin
          res_d.dst_we = 1'b1;
          res_d.dst = dec_val;
          if (dec_val != 32'h0) begin
            res_d.taken = 1'b1;
            res_d.pc = REQ.next_pc + loop_off;
          end
        end
      end
      bfm_pkg::OP_SWAP_FIELD: begin
        res_d.dst_we = 1'b1;
        res_d.dst = {26'h0, cfg_sel};
      end
      bfm_pkg::OP_SWAP_PC: begin
        res_d.dst_we = 1'b1;
        res_d.dst = REQ.next_pc;
        res_d.taken = 1'b1;
        res_d.pc = REQ.dst;
      end
      bfm_pkg::OP_READ_PC: begin
        res_d.dst_we = 1'b1;
        res_d.dst = REQ.next_pc;
      end
      bfm_pkg::OP_READ_FLAGS: begin
        res_d.dst_we = 1'b1;
        res_d.dst = FLAGS;
      end
      bfm_pkg::OP_ADD_ONE: begin
        res_d.dst_we = 1'b1;
        res_d.dst = REQ.dst + 32'h1;
      end
      bfm_pkg::OP_ABS_BR: begin
        if (cond_true) begin
          res_d.taken = 1'b1;
          res_d.pc = REQ.target;
        end
      end
      bfm_pkg::OP_REL_BR: begin
        bad_d = rel_bad;
        // an excluded displacement falls through rather than loop on itself
        if (cond_true && !rel_bad) begin
          res_d.taken = 1'b1;
          res_d.pc = REQ.next_pc + rel_off;
        end
      end
      bfm_pkg::OP_IND_JUMP: begin
        res_d.taken = 1'b1;
        res_d.pc = REQ.src;
      end
      bfm_pkg::OP_LEAD_ONE: begin
        res_d.dst_we = 1'b1;
        res_d.dst = {27'h0, `BFM_LEAD_TOP - lo_pos};
      end
      default: begin
        res_d.dst_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= bfm_pkg::S_IDLE;
    end else begin
      case (state_q)
        bfm_pkg::S_IDLE: begin
          if (take && REQ.op == bfm_pkg::OP_DEBUG_TRAP) begin
            state_q <= bfm_pkg::S_ACK;
          end else if (take && REQ.op == bfm_pkg::OP_LINE && LINE_IN.count != 16'h0) begin
            state_q <= bfm_pkg::S_LINE;
          end
        end
        bfm_pkg::S_ACK: state_q <= bfm_pkg::S_WAIT;
        bfm_pkg::S_WAIT: begin
          if (wait_end) begin
            state_q <= bfm_pkg::S_IDLE;
          end
        end
        bfm_pkg::S_LINE: begin
          if (line_end) begin
            state_q <= bfm_pkg::S_IDLE;
          end
        end
        default: state_q <= bfm_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      next_q <= 32'h0;
      line_var_q <= 1'b0;
    end else if (take) begin
      next_q <= REQ.next_pc;
      line_var_q <= REQ.line_var;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RES <= '0;
      RES_VALID <= 1'b0;
      BAD_DISP <= 1'b0;
    end else begin
      RES_VALID <= 1'b0;
      BAD_DISP <= 1'b0;
      if (take && REQ.op != bfm_pkg::OP_DEBUG_TRAP &&
          !(REQ.op == bfm_pkg::OP_LINE && LINE_IN.count != 16'h0)) begin
        RES <= res_d;
        RES_VALID <= 1'b1;
        BAD_DISP <= bad_d;
      end else if (wait_end || line_end) begin
        RES <= '{dst_we: 1'b0, dst: 32'h0, taken: 1'b0, pc: next_q};
        RES_VALID <= 1'b1;
      end
    end
  end

  // trap handshake: one-cycle ack, then wait out the emulator and the synchroniser
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DEBUG_ACK_N <= 1'b1;
      wait_q <= 2'h0;
    end else begin
      DEBUG_ACK_N <= !(take && REQ.op == bfm_pkg::OP_DEBUG_TRAP);
      wait_q <= (state_q == bfm_pkg::S_WAIT) ? wait_q + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EMULATE_MODE <= 1'b0;
    end else if (wait_end && !sel_s2_q) begin
      EMULATE_MODE <= 1'b1;
    end else if (EMULATE_EXIT) begin
      EMULATE_MODE <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GLOBAL_IRQ_ON <= 1'b0;
    end else if (take && REQ.op == bfm_pkg::OP_IRQ_ON) begin
      GLOBAL_IRQ_ON <= 1'b1;
    end else if (take && REQ.op == bfm_pkg::OP_IRQ_OFF) begin
      GLOBAL_IRQ_ON <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FIELD_CFG0 <= '{sign_ext: `BFM_FE_RST, width: `BFM_FS_RST};
      FIELD_CFG1 <= '{sign_ext: `BFM_FE_RST, width: `BFM_FS_RST};
    end else if (take && REQ.op == bfm_pkg::OP_SWAP_FIELD) begin
      if (REQ.field_sel) begin
        FIELD_CFG1 <= REQ.dst[`BFM_CFG_BITS-1:0];
      end else begin
        FIELD_CFG0 <= REQ.dst[`BFM_CFG_BITS-1:0];
      end
    end
  end

  assign d_pos = line_var_q ? ($signed(line_q.d) > 0) : ($signed(line_q.d) >= 0);
  assign line_step = {{15{line_q.b[15]}}, line_q.b, 1'b0} -
                     (d_pos ? {{15{line_q.a[15]}}, line_q.a, 1'b0} : 32'h0);
  assign d_next = line_q.d + line_step;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      line_q <= '0;
      PIXEL_STB <= 1'b0;
      PIXEL_ADDR <= 32'h0;
    end else begin
      PIXEL_STB <= 1'b0;
      if (take && REQ.op == bfm_pkg::OP_LINE) begin
        line_q <= LINE_IN;
      end else if (state_q == bfm_pkg::S_LINE) begin
        PIXEL_STB <= 1'b1;
        PIXEL_ADDR <= line_q.ptr;
        line_q.count <= line_q.count - 16'h1;
        line_q.d <= d_next;
        // x and y halves step separately so no carry leaks between them
        if (d_pos) begin
          line_q.ptr <= {line_q.ptr[31:16] + line_q.diag[31:16],
                         line_q.ptr[15:0] + line_q.diag[15:0]};
        end else begin
          line_q.ptr <= {line_q.ptr[31:16] + line_q.axial[31:16],
                         line_q.ptr[15:0] + line_q.axial[15:0]};
        end
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  a_dec_branch_taken: assert property (
    take && REQ.op == bfm_pkg::OP_DEC_SKIP && REQ.dst != 32'h1 |=>
      RES_VALID && RES.taken && RES.pc == $past(REQ.next_pc) + $past(loop_off))
    else $error("loop branch target wrong");
  a_dec_zero_falls: assert property (
    take && REQ.op == bfm_pkg::OP_DEC_SKIP && REQ.dst == 32'h1 |=>
      !RES.taken && RES.dst == 32'h0 && RES.pc == $past(REQ.next_pc))
    else $error("loop exit wrong");
  a_dec_eq_skip: assert property (
    take && REQ.op == bfm_pkg::OP_DEC_IF_EQ && !nz_z |=>
      RES_VALID && !RES.dst_we && !RES.taken)
    else $error("equal loop ran with flag clear");
  a_dec_ne_skip: assert property (
    take && REQ.op == bfm_pkg::OP_DEC_IF_NE && nz_z |=>
      RES_VALID && !RES.dst_we && !RES.taken)
    else $error("unequal loop ran with flag set");
  a_irq_gate: assert property (
    take && REQ.op == bfm_pkg::OP_IRQ_OFF |=> !GLOBAL_IRQ_ON && !IRQ_TAKE)
    else $error("interrupt passed global disable");
  a_irq_enable: assert property (
    take && REQ.op == bfm_pkg::OP_IRQ_ON |=> GLOBAL_IRQ_ON)
    else $error("global enable not set");
  a_trap_ack_pulse: assert property (
    take && REQ.op == bfm_pkg::OP_DEBUG_TRAP |=> !DEBUG_ACK_N ##1 DEBUG_ACK_N [*3] ##1 RES_VALID)
    else $error("trap handshake timing wrong");
  a_trap_run_nop: assert property (
    wait_end && sel_s2_q && !EMULATE_MODE |=> !EMULATE_MODE && !RES.dst_we && !RES.taken)
    else $error("run sample not a no-operation");
  a_trap_emulate: assert property (
    wait_end && !sel_s2_q |=> EMULATE_MODE)
    else $error("emulation not entered");
  a_swap_upper_zero: assert property (
    take && REQ.op == bfm_pkg::OP_SWAP_FIELD |=>
      RES.dst[31:6] == 26'h0 && RES.dst[5:0] == $past(cfg_sel))
    else $error("field swap result wrong");
  a_swap_pc_both: assert property (
    take && REQ.op == bfm_pkg::OP_SWAP_PC |=>
      RES.pc == $past(REQ.dst) && RES.dst == $past(REQ.next_pc))
    else $error("pc swap wrong");
  a_flags_copy: assert property (
    take && REQ.op == bfm_pkg::OP_READ_FLAGS |=> RES.dst == $past(FLAGS))
    else $error("flags copy wrong");
  a_add_one_value: assert property (
    take && REQ.op == bfm_pkg::OP_ADD_ONE |=> RES.dst == $past(REQ.dst) + 32'h1)
    else $error("increment wrong");
  a_jump_indirect: assert property (
    take && REQ.op == bfm_pkg::OP_IND_JUMP |=> RES.taken && RES.pc == $past(REQ.src))
    else $error("indirect jump wrong");
  a_lead_one_value: assert property (
    take && REQ.op == bfm_pkg::OP_LEAD_ONE && REQ.src == 32'h0000_8000 |=>
      RES.dst == 32'h0000_0010)
    else $error("leading one wrong");
  a_rel_zero_excl: assert property (
    take && REQ.op == bfm_pkg::OP_REL_BR && rel_bad |=> BAD_DISP && !RES.taken)
    else $error("excluded displacement branched");
  a_line_strobe: assert property (
    state_q == bfm_pkg::S_LINE |=> PIXEL_STB && PIXEL_ADDR == $past(line_q.ptr))
    else $error("line pixel missing");

  c_loop_taken: cover property (take && REQ.op == bfm_pkg::OP_DEC_SKIP ##1 RES.taken);
  c_emulate: cover property (wait_end && !sel_s2_q);
  c_line_done: cover property (line_end ##1 RES_VALID);
  c_field_swap: cover property (take && REQ.op == bfm_pkg::OP_SWAP_FIELD && REQ.field_sel);
endmodule
`default_nettype wire

// ==== design/bfm_lead_one.sv ====
`timescale 1ns/1ps
`default_nettype none
module bfm_lead_one (
  input wire logic [31:0] src,
  output logic [4:0] pos
);
  logic [31:0] above;
  logic [4:0] acc [0:32];

  assign above[31] = 1'b0;
  assign acc[0] = 5'h00;

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      if (i < 31) begin : g_above
        assign above[i] = above[i + 1] | src[i + 1];
      end
      // only the highest set bit contributes its index
      assign acc[i + 1] = acc[i] | ((src[i] & ~above[i]) ? 5'(i) : 5'h00);
    end
  endgenerate

  assign pos = acc[32];
endmodule
`default_nettype wire

// ==== design/bfm_pkg.sv ====
package bfm_pkg;

  typedef enum logic [4:0] {
    OP_DEC_SKIP, OP_DEC_IF_EQ, OP_DEC_IF_NE, OP_IRQ_ON, OP_IRQ_OFF,
    OP_DEBUG_TRAP, OP_SWAP_FIELD, OP_SWAP_PC, OP_READ_PC, OP_READ_FLAGS,
    OP_ADD_ONE, OP_ABS_BR, OP_REL_BR, OP_IND_JUMP, OP_LINE, OP_LEAD_ONE
  } bfm_op_e;

  typedef enum logic [3:0] {
    CC_ALWAYS, CC_EQ, CC_NE, CC_CS, CC_CC, CC_MI, CC_PL, CC_VS,
    CC_VC, CC_GT, CC_LE, CC_GE, CC_LT, CC_HI, CC_LS, CC_NEVER
  } bfm_cond_e;

  typedef enum logic [2:0] {S_IDLE, S_ACK, S_WAIT, S_LINE} bfm_state_e;

  typedef struct packed {
    bfm_op_e op;
    logic long_form;
    logic [15:0] disp;
    logic field_sel;
    bfm_cond_e cond;
    logic line_var;
    logic [31:0] dst;
    logic [31:0] src;
    logic [31:0] next_pc;
    logic [31:0] target;
  } bfm_req_s;

  typedef struct packed {
    logic dst_we;
    logic [31:0] dst;
    logic taken;
    logic [31:0] pc;
  } bfm_res_s;

  typedef struct packed {
    logic sign_ext;
    logic [4:0] width;
  } bfm_fcfg_s;

  typedef struct packed {
    logic [15:0] count;
    logic [31:0] d;
    logic [15:0] a;
    logic [15:0] b;
    logic [31:0] ptr;
    logic [31:0] diag;
    logic [31:0] axial;
  } bfm_line_s;

endpackage

// ==== test/bfm_emu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bfm_emulator_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic debug_ack_n,
  input wire logic run_choice,
  output logic halt_select
);
  logic [3:0] hold_q;

  // frozen for a while after the ack; the sampler sits behind two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 4'h0;
      halt_select <= 1'b1;
    end else if (!debug_ack_n) begin
      hold_q <= 4'h8;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end else begin
      halt_select <= run_choice;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [1:0] wk;
    logic [31:0] dst;
    logic tkc;
    logic tk;
    logic [31:0] pc;
    logic bad;
  } bfm_tb_exp_s;
  logic clk, rst_n, req_valid, emulate_exit, run_choice, halt_sel, t, bad;
  logic req_ready, res_valid, bad_disp, g_irq, irq_take, ack_n, emulate_mode, pix_stb;
  logic [31:0] flags, irq_mask, irq_pend, pix_addr, np, seed, d, e, off;
  bfm_pkg::bfm_req_s req, r;
  bfm_pkg::bfm_line_s line_in, line_out;
  bfm_pkg::bfm_res_s res;
  bfm_pkg::bfm_fcfg_s cfg0, cfg1;
  bfm_tb_exp_s ex, exp_q[$];
  logic [31:0] pix_q[$];
  logic [16:0] rel_tab [9] = '{17'h0007F, 17'h00081, 17'h00080, 17'h00000, 17'h00005,
    17'h17FFF, 17'h18001, 17'h18000, 17'h10000};
  int fails, samples_checked, ack_lows;

  bfm_exec dut (.REF_CLK(clk), .RESET_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ(req), .LINE_IN(line_in), .FLAGS(flags), .IRQ_MASK(irq_mask), .IRQ_PEND(irq_pend),
    .HALT_SELECT(halt_sel), .EMULATE_EXIT(emulate_exit), .RES(res), .RES_VALID(res_valid),
    .BAD_DISP(bad_disp), .GLOBAL_IRQ_ON(g_irq), .IRQ_TAKE(irq_take), .DEBUG_ACK_N(ack_n),
    .EMULATE_MODE(emulate_mode), .FIELD_CFG0(cfg0), .FIELD_CFG1(cfg1), .PIXEL_STB(pix_stb),
    .PIXEL_ADDR(pix_addr), .LINE_OUT(line_out));

  bfm_emulator_model u_emulator (.clk(clk), .rst_n(rst_n), .debug_ack_n(ack_n),
    .run_choice(run_choice), .halt_select(halt_sel));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic cond_ok(input logic [31:0] f, input logic [3:0] c);
    logic n, cy, z, v;
    {n, cy, z, v} = f[31:28];
    case (c)
      4'h0: return 1'b1;
      4'h1: return z;
      4'h2: return !z;
      4'h3: return cy;
      4'h4: return !cy;
      4'h5: return n;
      4'h6: return !n;
      4'h7: return v;
      4'h8: return !v;
      4'h9: return !((n ^ v) | z);
      4'hA: return (n ^ v) | z;
      4'hB: return !(n ^ v);
      4'hC: return n ^ v;
      4'hD: return !cy && !z;
      4'hE: return cy || z;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] xy(input logic [31:0] p, input logic [31:0] q);
    return {p[31:16] + q[31:16], p[15:0] + q[15:0]};
  endfunction

  task cmp32(input string nm, input logic [31:0] ev, input logic [31:0] gv);
    samples_checked++;
    if (gv !== ev) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  task final_report();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // results and pixels are judged in the cycle they stand
  always @(posedge clk) begin
    if (rst_n) begin
      if (ack_n === 1'b0) ack_lows++;
      if (pix_stb === 1'b1) begin
        if (pix_q.size() == 0) cmp32("pixel extra", 32'h0, 32'h1);
        else cmp32("pixel addr", pix_q.pop_front(), pix_addr);
      end
      if (res_valid === 1'b1) begin
        if (exp_q.size() == 0) cmp32("result extra", 32'h0, 32'h1);
        else begin
          ex = exp_q.pop_front();
          cmp32("bad disp", {31'h0, ex.bad}, {31'h0, bad_disp});
          cmp32("pc", ex.pc, res.pc);
          if (ex.tkc) cmp32("taken", {31'h0, ex.tk}, {31'h0, res.taken});
          if (ex.wk != 2'h2 && !(ex.wk == 2'h3 && res.dst_we === 1'b1))
            cmp32("dst we", {31'h0, ex.wk == 2'h1}, {31'h0, res.dst_we});
          if (ex.wk == 2'h1 || (ex.wk == 2'h3 && res.dst_we === 1'b1))
            cmp32("dst", ex.dst, res.dst);
        end
      end
    end
  end

  // wk: 0 no write, 1 write, 2 ignore, 3 no write or same value; tk: 0, 1, 2 ignore
  task op(input bfm_pkg::bfm_op_e o, input logic [31:0] dv, input logic [1:0] wk,
      input logic [31:0] ed, input logic [1:0] tk, input logic [31:0] ep, input logic eb);
    int n;
    n = 0;
    if (req_ready !== 1'b1) req_valid = 1'b0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      fails++;
      final_report();
    end
    r.op = o;
    r.dst = dv;
    r.next_pc = np;
    req = r;
    req_valid = 1'b1;
    exp_q.push_back('{wk, ed, tk != 2'h2, tk[0], ep, eb});
    @(posedge clk);
    #1;
    np = rnd() & 32'hFFFF_FFF0;
  endtask

  task idle(input int n);
    req_valid = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task line_case(input logic v, input logic [15:0] cnt);
    bfm_pkg::bfm_line_s m;
    logic go;
    m = '{cnt, 32'h0, 16'h0003, 16'h0001, 32'h0010_0020, 32'h0001_0001, 32'h0001_FFFF};
    line_in = m;
    r.line_var = v;
    while (m.count != 16'h0) begin
      pix_q.push_back(m.ptr);
      go = v ? ($signed(m.d) > 0) : ($signed(m.d) >= 0);
      m.d = m.d + {{15{m.b[15]}}, m.b, 1'b0} - (go ? {{15{m.a[15]}}, m.a, 1'b0} : 32'h0);
      m.ptr = xy(m.ptr, go ? m.diag : m.axial);
      m.count = m.count - 16'h1;
    end
    op(bfm_pkg::OP_LINE, 32'h0, 2'h2, 32'h0, 2'h2, np, 1'b0);
    idle(cnt + 3);
    if (cnt != 16'h0) begin
      cmp32("line d", m.d, line_out.d);
      cmp32("line ptr", m.ptr, line_out.ptr);
      cmp32("line count", 32'h0, {16'h0, line_out.count});
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    r = '0;
    req = '0;
    line_in = '0;
    flags = 32'h0;
    irq_mask = 32'h0;
    irq_pend = 32'h0;
    emulate_exit = 1'b0;
    run_choice = 1'b1;
    seed = 32'h8426F42D;
    np = 32'h0000_1000;
    fails = 0;
    samples_checked = 0;
    ack_lows = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    d = rnd();
    op(bfm_pkg::OP_ADD_ONE, d, 2'h1, d + 32'h1, 2'h2, np, 1'b0);
    op(bfm_pkg::OP_ADD_ONE, 32'hFFFF_FFFF, 2'h1, 32'h0, 2'h2, np, 1'b0);
    r.disp = 16'h0001;
    op(bfm_pkg::OP_DEC_SKIP, 32'h3, 2'h1, 32'h2, 2'h1, np + 32'h20, 1'b0);
    r.disp = 16'h003F;
    op(bfm_pkg::OP_DEC_SKIP, 32'h7, 2'h1, 32'h6, 2'h1, np - 32'h200, 1'b0);
    op(bfm_pkg::OP_DEC_SKIP, 32'h1, 2'h1, 32'h0, 2'h0, np, 1'b0);
    r.long_form = 1'b1;
    r.disp = 16'h8000;
    op(bfm_pkg::OP_DEC_SKIP, 32'h9, 2'h1, 32'h8, 2'h1, np - 32'h80000, 1'b0);
    r.disp = 16'h7FFF;
    op(bfm_pkg::OP_DEC_SKIP, 32'h5, 2'h1, 32'h4, 2'h1, np + 32'h7FFF0, 1'b0);
    r.long_form = 1'b0;
    r.disp = 16'h0001;
    flags = 32'h2000_0000;
    op(bfm_pkg::OP_DEC_IF_EQ, 32'h4, 2'h1, 32'h3, 2'h1, np + 32'h20, 1'b0);
    op(bfm_pkg::OP_DEC_IF_NE, 32'h4, 2'h3, 32'h4, 2'h0, np, 1'b0);
    flags = 32'h0;
    op(bfm_pkg::OP_DEC_IF_EQ, 32'h4, 2'h3, 32'h4, 2'h0, np, 1'b0);
    op(bfm_pkg::OP_DEC_IF_NE, 32'h4, 2'h1, 32'h3, 2'h1, np + 32'h20, 1'b0);
    irq_mask = 32'h4;
    irq_pend = 32'h4;
    op(bfm_pkg::OP_IRQ_ON, 32'h0, 2'h0, 32'h0, 2'h2, np, 1'b0);
    idle(1);
    cmp32("irq on", 32'h1, {31'h0, g_irq});
    cmp32("irq take", 32'h1, {31'h0, irq_take});
    irq_mask = 32'h0;
    idle(1);
    cmp32("irq masked", 32'h0, {31'h0, irq_take});
    irq_mask = 32'h4;
    op(bfm_pkg::OP_IRQ_OFF, 32'h0, 2'h0, 32'h0, 2'h2, np, 1'b0);
    idle(1);
    cmp32("irq off", 32'h0, {31'h0, g_irq});
    cmp32("irq blocked", 32'h0, {31'h0, irq_take});
    for (int k = 0; k < 2; k++) begin
      run_choice = k[0] ? 1'b0 : 1'b1;
      idle(12);
      ack_lows = 0;
      op(bfm_pkg::OP_DEBUG_TRAP, 32'h0, 2'h0, 32'h0, 2'h2, np, 1'b0);
      idle(8);
      cmp32("ack pulses", 32'h1, 32'(ack_lows));
      cmp32("emulate mode", {31'h0, k[0]}, {31'h0, emulate_mode});
    end
    emulate_exit = 1'b1;
    idle(2);
    emulate_exit = 1'b0;
    cmp32("emulate exit", 32'h0, {31'h0, emulate_mode});
    d = rnd();
    e = rnd();
    op(bfm_pkg::OP_SWAP_FIELD, d, 2'h1, 32'h0, 2'h2, np, 1'b0);
    op(bfm_pkg::OP_SWAP_FIELD, e, 2'h1, {26'h0, d[5:0]}, 2'h2, np, 1'b0);
    r.field_sel = 1'b1;
    op(bfm_pkg::OP_SWAP_FIELD, d, 2'h1, 32'h0, 2'h2, np, 1'b0);
    idle(1);
    cmp32("cfg0", {26'h0, e[5:0]}, {26'h0, cfg0});
    cmp32("cfg1", {26'h0, d[5:0]}, {26'h0, cfg1});
    d = rnd() & 32'hFFFF_FFF0;
    op(bfm_pkg::OP_SWAP_PC, d, 2'h1, np, 2'h2, d, 1'b0);
    op(bfm_pkg::OP_READ_PC, d, 2'h1, np, 2'h2, np, 1'b0);
    flags = rnd();
    op(bfm_pkg::OP_READ_FLAGS, d, 2'h1, flags, 2'h2, np, 1'b0);
    r.src = rnd();
    op(bfm_pkg::OP_IND_JUMP, d, 2'h0, 32'h0, 2'h2, r.src, 1'b0);
    for (int k = 0; k < 32; k++) begin
      flags = k < 16 ? 32'hA000_0000 : 32'h5000_0000;
      if (k < 29 || k > 30) begin
        r.cond = bfm_pkg::bfm_cond_e'(k[3:0]);
        t = cond_ok(flags, k[3:0]);
        r.target = rnd();
        e = t ? r.target : np;
        op(bfm_pkg::OP_ABS_BR, 32'h0, 2'h0, 32'h0, {1'b0, t}, e, 1'b0);
      end
    end
    for (int k = 0; k < 9; k++) begin
      {r.long_form, r.disp} = rel_tab[k];
      off = r.long_form ? {{16{r.disp[15]}}, r.disp} : {{24{r.disp[7]}}, r.disp[7:0]};
      bad = off == 32'h0 || off == (r.long_form ? 32'hFFFF_8000 : 32'hFFFF_FF80);
      r.cond = k == 4 ? bfm_pkg::CC_NEVER : bfm_pkg::CC_ALWAYS;
      t = !bad && k != 4;
      e = t ? np + off : np;
      op(bfm_pkg::OP_REL_BR, 32'h0, 2'h0, 32'h0, {1'b0, t}, e, bad);
    end
    line_case(1'b0, 16'h2);
    line_case(1'b1, 16'h2);
    line_case(1'b0, 16'h5);
    line_case(1'b1, 16'h0);
    for (int k = 0; k < 8; k++) begin
      r.src = k == 0 ? 32'h0 : (k == 1 ? 32'h1 : (rnd() | 32'h1) >> (k * 4));
      if (k == 7) r.src = 32'h0000_8000;
      e = 32'h1F;
      for (int b = 0; b < 32; b++) if (r.src[b]) e = 32'(31 - b);
      op(bfm_pkg::OP_LEAD_ONE, 32'hFFFF_FFFF, 2'h1, e, 2'h2, np, 1'b0);
    end
    idle(6);
    cmp32("results left", 32'h0, 32'(exp_q.size()));
    cmp32("pixels left", 32'h0, 32'(pix_q.size()));
    final_report();
  end
endmodule
`default_nettype wire
